/* rtl/blpwm_pkg.sv */
// Package of constants for the backlight PWM and frame divider block
// Operation
// RULE1 - The frame tick period is 3072 clocks for frame select 00, 1536 when bit 0 is set and 768 when bit 1 is set; the code gives 3072 for frame select 11.
// RULE2 - The PWM period is 1536 clocks for frequency code 0, falling by 128 per step to 256 at code 10; codes 11 to 15 are undefined.
// RULE3 - Each output is high for (duty code + 1) of the 64 steps of a PWM period and low for the rest.
// RULE4 - Everything resets at power-up and again while the supply-drop detector reports a low logic supply; the code resets read data on sys_rst only.
// RULE5 - The host should discard any key data word that shows three or more pressed keys.
// RULE6 - Each of the three outputs has its own 6-bit duty code, selected by channel index.
// RULE7 - Outputs stay low after reset until the display-technique write and then the port-state write have been made.
// RULE8 - One shared 64-step counter paces all three channels so they stay phase aligned.
package blpwm_pkg;

  localparam int unsigned NUM_CH        = 3;
  localparam int unsigned DUTY_W        = 6;
  localparam int unsigned STEPS_W       = 6;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_TECH      = 8'h00; // Display technique: frame select
  localparam logic [7:0] ADDR_PORT      = 8'h04; // Port state: PWM frequency select
  localparam logic [7:0] ADDR_DUTY1     = 8'h08;
  localparam logic [7:0] ADDR_DUTY2     = 8'h0c;
  localparam logic [7:0] ADDR_DUTY3     = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;

  // Status fields
  localparam int unsigned ST_TECH_BIT   = 0;
  localparam int unsigned ST_ARMED_BIT  = 1;
  localparam int unsigned ST_DET_BIT    = 2;

  // Frame divisors
  localparam logic [11:0] FRAME_DIV_00  = 12'hc00; // 3072
  localparam logic [11:0] FRAME_DIV_B0  = 12'h600; // 1536
  localparam logic [11:0] FRAME_DIV_B1  = 12'h300; // 768

  // PWM period = 64 steps; step length in clocks = period / 64
  localparam logic [4:0]  STEP_LEN_BASE = 5'h18;   // 1536 / 64
  localparam logic [4:0]  STEP_LEN_DEC  = 5'h02;   // 128 / 64
  localparam logic [3:0]  FREQ_CODE_MAX = 4'ha;    // 256 / 64 = 4 clocks

  localparam logic [1:0]  FRAME_SEL_RST = 2'h0;
  localparam logic [3:0]  FREQ_SEL_RST  = 4'h0;
  localparam logic [5:0]  DUTY_RST      = 6'h00;

  typedef enum logic [1:0] {
    BLPWM_OFF   = 2'b00, // Outputs forced low, technique not yet written
    BLPWM_TECH  = 2'b01, // Technique set, waiting for port state
    BLPWM_RUN   = 2'b10  // Outputs follow the PWM compare
  } blpwm_state_e;

endpackage : blpwm_pkg

/* rtl/blpwm_cfg_if.sv */
// Interface carrying configuration and timing between the block's modules
`timescale 1ns/1ps
`default_nettype none
interface blpwm_cfg_if;
  logic                                                   clr;        // Synchronous clear
  logic [1:0]                                             frame_sel;  // Frame select field
  logic [3:0]                                             freq_sel;   // PWM frequency code
  logic [blpwm_pkg::NUM_CH-1:0][blpwm_pkg::DUTY_W-1:0]    duty;       // Duty codes
  logic                                                   armed;      // Outputs enabled
  logic                                                   frame_tick; // One pulse per frame
  logic [blpwm_pkg::STEPS_W-1:0]                          step;       // Shared step count
  logic [blpwm_pkg::NUM_CH-1:0]                           pwm_out;    // Channel levels

  modport ctrl (output clr, frame_sel, freq_sel, duty, armed,
                input  frame_tick, step, pwm_out);
  modport div  (input clr, frame_sel, output frame_tick);
  modport pwm  (input clr, freq_sel, duty, armed, output step, pwm_out);
endinterface : blpwm_cfg_if
`default_nettype wire

/* rtl/blpwm_frame_div.sv */
// Frame frequency divider
`timescale 1ns/1ps
`default_nettype none
module blpwm_frame_div (
  input  wire logic   ref_clk, // Block clock
  input  wire logic   sys_rst, // Async reset, high
  blpwm_cfg_if.div    cfg      // Configuration and frame tick
);
  logic [11:0] cnt_reg;
  logic [11:0] div_sel;
  logic        wrap;

  // Select divisor; undefined code 11 falls back to the slowest rate
  assign div_sel = (cfg.frame_sel == 2'b01) ? blpwm_pkg::FRAME_DIV_B0 : // RULE1
                   (cfg.frame_sel == 2'b10) ? blpwm_pkg::FRAME_DIV_B1 : // RULE1
                   blpwm_pkg::FRAME_DIV_00;                             // RULE1
  // Compare with >= so a lower divisor chosen mid-frame restarts cleanly
  assign wrap = (cnt_reg >= div_sel - 12'h001);

  // Free-running frame counter with one-cycle tick on wrap
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg        <= 12'h000;
      cfg.frame_tick <= 1'b0;
    end else if (cfg.clr) begin // RULE4
      cnt_reg        <= 12'h000;
      cfg.frame_tick <= 1'b0;
    end else begin
      cnt_reg        <= wrap ? 12'h000 : cnt_reg + 12'h001;
      cfg.frame_tick <= wrap;
    end
  end
endmodule : blpwm_frame_div
`default_nettype wire

/* rtl/blpwm_pwm_core.sv */
// Shared step counter and three duty comparators
`timescale 1ns/1ps
`default_nettype none
module blpwm_pwm_core (
  input  wire logic   ref_clk, // Block clock
  input  wire logic   sys_rst, // Async reset, high
  blpwm_cfg_if.pwm    cfg      // Configuration and PWM levels
);
  logic [4:0] pre_reg;
  logic [3:0] code_eff;
  logic [4:0] step_len;
  logic       step_end;
  logic [blpwm_pkg::STEPS_W-1:0] step_reg;

  // Undefined codes clamp to the fastest defined rate
  assign code_eff = (cfg.freq_sel > blpwm_pkg::FREQ_CODE_MAX) ?
                    blpwm_pkg::FREQ_CODE_MAX : cfg.freq_sel;
  // Step length = (1536 - 128*code) / 64 clocks
  assign step_len = blpwm_pkg::STEP_LEN_BASE -
                    5'(blpwm_pkg::STEP_LEN_DEC * {1'b0, code_eff}); // RULE2
  assign step_end = (pre_reg >= step_len - 5'h01);
  assign cfg.step = step_reg;

  // Prescaler and 64-step counter shared by all channels
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_reg  <= 5'h00;
      step_reg <= '0;
    end else if (cfg.clr) begin // RULE4
      pre_reg  <= 5'h00;
      step_reg <= '0;
    end else begin
      pre_reg  <= step_end ? 5'h00 : pre_reg + 5'h01;
      if (step_end) begin
        step_reg <= step_reg + 6'h01; // RULE8
      end
    end
  end

  // One comparator per channel against the common step count
  for (genvar ch = 0; ch < blpwm_pkg::NUM_CH; ch++) begin : g_ch
    logic lvl_reg;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        lvl_reg <= 1'b0;
      end else if (cfg.clr || !cfg.armed) begin // RULE7
        lvl_reg <= 1'b0;
      end else begin
        lvl_reg <= (step_reg <= cfg.duty[ch]); // RULE3 RULE6 RULE8
      end
    end
    assign cfg.pwm_out[ch] = lvl_reg;
  end
endmodule : blpwm_pwm_core
`default_nettype wire

/* rtl/blpwm_top.sv */
// Top of the backlight PWM and frame divider block with its register port
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module blpwm_top (
  input  wire logic        ref_clk,              // 25 MHz block clock
  input  wire logic        sys_rst,              // Async reset, high
  input  wire logic        supply_drop_detector, // High while logic supply is low
  input  wire logic [7:0]  addr,                 // Register byte address
  input  wire logic [7:0]  wdata,                // Write data
  input  wire logic        wr,                   // Write strobe
  input  wire logic        rd,                   // Read strobe
  output logic      [7:0]  rdata,                // Read data, cycle after rd
  output logic             gp_out_one,           // PWM output 1
  output logic             gp_out_two,           // PWM output 2
  output logic             gp_out_three,         // PWM output 3
  output logic             frame_tick            // One pulse per frame period
);
  blpwm_cfg_if cfg ();

  logic                det_meta_reg;
  logic                det_sync_reg;
  blpwm_pkg::blpwm_state_e state_reg;
  blpwm_pkg::blpwm_state_e state_next;
  logic [1:0]          frame_sel_reg;
  logic [3:0]          freq_sel_reg;
  logic [blpwm_pkg::NUM_CH-1:0][blpwm_pkg::DUTY_W-1:0] duty_reg;
  logic [7:0]          rdata_reg;
  logic [7:0]          rd_mux;
  logic                wr_tech;
  logic                wr_port;
  logic [blpwm_pkg::NUM_CH-1:0] wr_duty;
  logic [7:0]          status_val;

  // Two-stage synchroniser for the asynchronous supply detector
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      det_meta_reg <= 1'b1;
      det_sync_reg <= 1'b1;
    end else begin
      det_meta_reg <= supply_drop_detector;
      det_sync_reg <= det_meta_reg;
    end
  end

  // Detector holds every register but the synchroniser and read data in reset like sys_rst does
  assign cfg.clr = det_sync_reg; // RULE4

  // Write decode
  assign wr_tech    = wr && (addr == blpwm_pkg::ADDR_TECH);
  assign wr_port    = wr && (addr == blpwm_pkg::ADDR_PORT);
  assign wr_duty[0] = wr && (addr == blpwm_pkg::ADDR_DUTY1);
  assign wr_duty[1] = wr && (addr == blpwm_pkg::ADDR_DUTY2);
  assign wr_duty[2] = wr && (addr == blpwm_pkg::ADDR_DUTY3);

  // Enable sequence: technique first, then port state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      blpwm_pkg::BLPWM_OFF:  begin
        if (wr_tech) begin
          state_next = blpwm_pkg::BLPWM_TECH; // RULE7
        end
      end
      blpwm_pkg::BLPWM_TECH: begin
        if (wr_port) begin
          state_next = blpwm_pkg::BLPWM_RUN; // RULE7
        end
      end
      blpwm_pkg::BLPWM_RUN:  state_next = blpwm_pkg::BLPWM_RUN;
      default:               state_next = blpwm_pkg::BLPWM_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= blpwm_pkg::BLPWM_OFF;
    end else if (det_sync_reg) begin // RULE4
      state_reg <= blpwm_pkg::BLPWM_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfg.armed = (state_reg == blpwm_pkg::BLPWM_RUN); // RULE7

  // Configuration registers; a port write before the technique is still stored
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_sel_reg <= blpwm_pkg::FRAME_SEL_RST;
      freq_sel_reg  <= blpwm_pkg::FREQ_SEL_RST;
    end else if (det_sync_reg) begin // RULE4
      frame_sel_reg <= blpwm_pkg::FRAME_SEL_RST;
      freq_sel_reg  <= blpwm_pkg::FREQ_SEL_RST;
    end else begin
      if (wr_tech) begin
        frame_sel_reg <= wdata[1:0]; // RULE1
      end
      if (wr_port) begin
        freq_sel_reg <= wdata[3:0]; // RULE2
      end
    end
  end

  // One duty register per channel
  for (genvar ch = 0; ch < blpwm_pkg::NUM_CH; ch++) begin : g_duty
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        duty_reg[ch] <= blpwm_pkg::DUTY_RST;
      end else if (det_sync_reg) begin // RULE4
        duty_reg[ch] <= blpwm_pkg::DUTY_RST;
      end else if (wr_duty[ch]) begin
        duty_reg[ch] <= wdata[blpwm_pkg::DUTY_W-1:0]; // RULE6
      end
    end
  end

  assign cfg.frame_sel = frame_sel_reg;
  assign cfg.freq_sel  = freq_sel_reg;
  assign cfg.duty      = duty_reg;

  // Status shows the enable sequence and, in bits 5:2, step bits 5:2 with the detector level ORed into bit 2
  assign status_val = {2'h0, cfg.step[5:2], 2'h0} |
                      (8'(state_reg != blpwm_pkg::BLPWM_OFF) << blpwm_pkg::ST_TECH_BIT) |
                      (8'(cfg.armed) << blpwm_pkg::ST_ARMED_BIT) |
                      (8'(det_sync_reg) << blpwm_pkg::ST_DET_BIT);

  // Read mux; unmapped addresses read zero
  assign rd_mux = (addr == blpwm_pkg::ADDR_TECH)   ? {6'h00, frame_sel_reg} :
                  (addr == blpwm_pkg::ADDR_PORT)   ? {4'h0, freq_sel_reg}   :
                  (addr == blpwm_pkg::ADDR_DUTY1)  ? {2'h0, duty_reg[0]}    :
                  (addr == blpwm_pkg::ADDR_DUTY2)  ? {2'h0, duty_reg[1]}    :
                  (addr == blpwm_pkg::ADDR_DUTY3)  ? {2'h0, duty_reg[2]}    :
                  (addr == blpwm_pkg::ADDR_STATUS) ? status_val             :
                  8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd ? rd_mux : 8'h00;
    end
  end
  assign rdata = rdata_reg;

  blpwm_frame_div u_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cfg     (cfg.div)
  );

  blpwm_pwm_core u_pwm (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .cfg     (cfg.pwm)
  );

  // Channel levels are already registered in the core
  assign gp_out_one   = cfg.pwm_out[0];
  assign gp_out_two   = cfg.pwm_out[1];
  assign gp_out_three = cfg.pwm_out[2];
  assign frame_tick   = cfg.frame_tick;
endmodule : blpwm_top
`default_nettype wire

/* tb/blpwm_sva.sv */
// Port checker for the backlight PWM and frame divider block
`timescale 1ns/1ps
`default_nettype none
module blpwm_sva (
  input wire logic       ref_clk,              // Clock
  input wire logic       sys_rst,              // Reset
  input wire logic       supply_drop_detector, // Supply low
  input wire logic [7:0] addr,                 // Address
  input wire logic [7:0] wdata,                // Write data
  input wire logic       wr,                   // Write
  input wire logic       rd,                   // Read
  input wire logic [7:0] rdata,                // Read data
  input wire logic       gp_out_one,           // Output 1
  input wire logic       gp_out_two,           // Output 2
  input wire logic       gp_out_three,         // Output 3
  input wire logic       frame_tick            // Frame pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [11:0] quiet_reg;
  logic [12:0] gap_reg;
  logic        gap_ok_reg;
  logic        any_out;
  assign any_out = gp_out_one | gp_out_two | gp_out_three;
  // Gap is only trusted from a tick after the last frame select write or clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_reg <= 12'h000;
      gap_reg <= 13'h0000;
      gap_ok_reg <= 1'b0;
    end else begin
      quiet_reg <= (wr || supply_drop_detector) ? 12'h000 : quiet_reg + {11'h000, ~&quiet_reg};
      gap_reg <= frame_tick ? 13'h0001 : gap_reg + 13'h0001;
      gap_ok_reg <= (supply_drop_detector || (wr && addr == blpwm_pkg::ADDR_TECH)) ? 1'b0
                    : (frame_tick | gap_ok_reg);
    end
  end
  chk_reset_low: assert property ($fell(sys_rst) |-> !any_out && !frame_tick)
    else $error("outputs not low after reset");
  chk_drop_low: assert property (supply_drop_detector [*5] |-> !any_out)
    else $error("outputs not low during supply drop");
  chk_tick_pulse: assert property (frame_tick |=> !frame_tick)
    else $error("frame tick longer than one cycle");
  chk_frame_gap: assert property (frame_tick && gap_ok_reg |-> gap_reg inside {768, 1536, 3072})
    else $error("frame tick spacing wrong");
  chk_phase_align: assert property (quiet_reg > 12'h640 && ($rose(gp_out_one) ||
    $rose(gp_out_two) || $rose(gp_out_three)) |-> gp_out_one && gp_out_two && gp_out_three)
    else $error("channels not phase aligned");
  chk_arm_status: assert property (rd && addr == blpwm_pkg::ADDR_STATUS && any_out
    && !supply_drop_detector |=> rdata[1]) else $error("output active while not armed");
  chk_rd_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside read answer");
  chk_unmapped_rd: assert property (rd && addr > 8'h14 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : blpwm_sva
bind blpwm_top blpwm_sva chk (.ref_clk, .sys_rst, .supply_drop_detector, .addr, .wdata, .wr,
  .rd, .rdata, .gp_out_one, .gp_out_two, .gp_out_three, .frame_tick);
`default_nettype wire

/* tb/blpwm_host.sv */
// Host controller model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module blpwm_host (
  input wire logic  ref_clk, // Clock
  output var logic [7:0] addr,  // Address
  output var logic [7:0] wdata, // Write data
  output var logic  wr,      // Write strobe
  output var logic  rd,      // Read strobe
  input wire logic [7:0] rdata  // Read data
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write strobe; the slave never stalls
  task automatic put_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : put_reg
  // Read data stands only in the cycle after the strobe
  task automatic get_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    v = rdata;
  endtask : get_reg
  // Words with three or more pressed keys may hold ghosts, so they are dropped
  function automatic logic key_word_ok(input logic [34:0] w);
    return $countones(w) < 3;
  endfunction : key_word_ok
endmodule : blpwm_host
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the backlight PWM and frame divider block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, sys_rst, drop, wr, rd, o1, o2, o3, tick, q;
  logic [7:0] addr, wdata, rdata, d;
  int fail_count, check_count, cyc;
  blpwm_top dut (.ref_clk, .sys_rst, .supply_drop_detector(drop), .addr, .wdata, .wr, .rd,
    .rdata, .gp_out_one(o1), .gp_out_two(o2), .gp_out_three(o3), .frame_tick(tick));
  blpwm_host host (.ref_clk, .addr, .wdata, .wr, .rd, .rdata);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // Counts samples with any output high
  task automatic low_for(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(negedge ref_clk);
      // An unknown level counts as high so that it cannot slip through
      hi += int'((o1 | o2 | o3) !== 1'b0);
    end
  endtask : low_for
  // Cycles until the next frame pulse, bounded
  task automatic wtick(output int t);
    t = 0;
    do begin
      @(negedge ref_clk);
      t++;
    end while (!tick && t < 4000);
  endtask : wtick
  function automatic int per(input int c);
    return 1536 - 128 * ((c > 10) ? 10 : c);
  endfunction : per
  function automatic int fper(input int s);
    return (s == 1) ? 1536 : (s == 2) ? 768 : 3072;
  endfunction : fper
  // A hung wait still reaches the verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    int p, n[3], du[3], t;
    sys_rst = 1'b1;
    drop = 1'b0;
    void'($urandom(32'h87d1));
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int a = 0; a < 5; a++) begin
      host.get_reg(8'(a * 4), d);
      check(32'(d), 0);
    end
    // Port state before technique must not arm the outputs
    host.put_reg(blpwm_pkg::ADDR_PORT, 8'h0a);
    low_for(300, t);
    check(t, 0);
    host.put_reg(blpwm_pkg::ADDR_TECH, 8'h00);
    host.put_reg(blpwm_pkg::ADDR_PORT, 8'h0a);
    host.get_reg(blpwm_pkg::ADDR_STATUS, d);
    check(32'(d[1:0]), 3);
    for (int i = 0; i < 8; i++) begin
      p = 8 + 4 * ($urandom % 3);
      t = $urandom % 256;
      host.put_reg(8'(p), 8'(t));
      host.get_reg(8'(p), d);
      check(32'(d), t & 63);
    end
    host.get_reg(8'h40, d);
    check(32'(d), 0);
    $display("registers done");
    // Frequency codes 0 to 12 with random and extreme duty codes
    for (int c = 0; c < 13; c++) begin
      du[0] = $urandom % 63;
      du[1] = (c == 0) ? 0 : $urandom % 64;
      du[2] = (c == 1) ? 63 : $urandom % 64;
      host.put_reg(blpwm_pkg::ADDR_PORT, 8'(c));
      for (int k = 0; k < 3; k++) host.put_reg(8'(8 + 4 * k), 8'(du[k]));
      p = per(c);
      q = 1'b1;
      t = 0;
      while (!(o1 && !q) && t < 4000) begin
        q = o1;
        @(negedge ref_clk);
        t++;
      end
      n = '{0, 0, 0};
      repeat (p) begin
        n[0] += int'(o1 !== 1'b0);
        n[1] += int'(o2 !== 1'b0);
        n[2] += int'(o3 !== 1'b0);
        q = o1;
        @(negedge ref_clk);
      end
      check(32'({q, o1}), 1);
      for (int k = 0; k < 3; k++) check(n[k], (du[k] + 1) * p / 64);
      // Status read while outputs run, so an active output is seen beside the armed bit
      host.get_reg(blpwm_pkg::ADDR_STATUS, d);
      check(32'(d[1:0]), 3);
    end
    $display("pwm done");
    for (int s = 0; s < 4; s++) begin
      host.put_reg(blpwm_pkg::ADDR_TECH, 8'(s));
      wtick(t);
      wtick(t);
      check(t, fper(s));
    end
    $display("frame done");
    // Supply drop clears every register but the synchroniser and read data, and disarms
    @(posedge ref_clk);
    drop <= 1'b1;
    low_for(6, t);
    low_for(4, t);
    check(t, 0);
    @(posedge ref_clk);
    drop <= 1'b0;
    repeat (4) @(posedge ref_clk);
    host.get_reg(blpwm_pkg::ADDR_DUTY1, d);
    check(32'(d), 0);
    low_for(300, t);
    check(t, 0);
    $display("supply drop done");
    // Host-side ghost filter: two keys kept, three keys dropped
    check(32'(host.key_word_ok(35'h5)), 1);
    check(32'(host.key_word_ok(35'h7)), 0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
